//--- foc_readback_consts.svh
`ifndef FOC_READBACK_CONSTS_SVH
`define FOC_READBACK_CONSTS_SVH

// ----------------------------------------
// register indices, byte address = 4 x index
// ----------------------------------------
`define IDX_SUPPLY_BUS_VOLTAGE 11'h47A
`define IDX_PHASE_A_VOLTAGE    11'h47E
`define IDX_PHASE_B_VOLTAGE    11'h480
`define IDX_PHASE_C_VOLTAGE    11'h482
`define IDX_ANGLE_SINE         11'h4BA
`define IDX_ANGLE_COSINE       11'h4BC
`define IDX_ALPHA_AXIS_CURRENT 11'h4D2
`define IDX_BETA_AXIS_CURRENT  11'h4D4
`define IDX_ALPHA_AXIS_VOLTAGE 11'h4D6
`define IDX_READBACK_CONTROL   11'h4F0
`define IDX_READBACK_STATUS    11'h4F2

// ----------------------------------------
// sizes, reset values, field positions
// ----------------------------------------
`define OBS_COUNT              9
`define OBS_WIDTH              32
`define MIN_ADDR_W             13
`define OBS_RESET              32'h00000000
`define CONTROL_RESET          1'h0
`define CONTROL_FREEZE_BIT     0
`define STATUS_FRESH_LSB       0
`define STATUS_ISD_BIT         16
`define STATUS_FREEZE_BIT      17

`endif

//--- foc_readback_pkg.sv
package foc_readback_pkg;

  // ----------------------------------------
  // bus answer sequencer
  // ----------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_type;

  // ----------------------------------------
  // slot of each observation word
  // ----------------------------------------
  typedef enum logic [3:0] {
    SLOT_SUPPLY_BUS_VOLTAGE = 4'h0,
    SLOT_PHASE_A_VOLTAGE    = 4'h1,
    SLOT_PHASE_B_VOLTAGE    = 4'h2,
    SLOT_PHASE_C_VOLTAGE    = 4'h3,
    SLOT_ANGLE_SINE         = 4'h4,
    SLOT_ANGLE_COSINE       = 4'h5,
    SLOT_ALPHA_AXIS_CURRENT = 4'h6,
    SLOT_BETA_AXIS_CURRENT  = 4'h7,
    SLOT_ALPHA_AXIS_VOLTAGE = 4'h8
  } obs_slot_type;

endpackage

//--- obs_word.sv
`timescale 1ns/1ps
`include "foc_readback_consts.svh"

module obs_word #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // algorithm side
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] value_in,
  // readback
  output logic      [WIDTH-1:0] value_q
);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  generate
    if (WIDTH < 1 || WIDTH > `OBS_WIDTH) begin : g_bad_width
      $error("obs_word width must lie in 1..32");
    end
  endgenerate

  // ----------------------------------------
  // holding register
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      value_q <= WIDTH'(`OBS_RESET);
    end else if (load) begin
      value_q <= value_in;
    end
  end

endmodule

//--- foc_algorithm_variable_readback.sv
`timescale 1ns/1ps
`include "foc_readback_consts.svh"

module foc_algorithm_variable_readback #(
  parameter int ADDR_W = 13
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // avalon-mm slave, byte addressed
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // algorithm state
  input  wire logic              initial_speed_detection,
  // algorithm results, each with a load strobe
  input  wire logic [31:0]       supply_bus_voltage_in,
  input  wire logic              supply_bus_voltage_ld,
  input  wire logic [31:0]       phase_a_voltage_in,
  input  wire logic              phase_a_voltage_ld,
  input  wire logic [31:0]       phase_b_voltage_in,
  input  wire logic              phase_b_voltage_ld,
  input  wire logic [31:0]       phase_c_voltage_in,
  input  wire logic              phase_c_voltage_ld,
  input  wire logic [31:0]       angle_sine_in,
  input  wire logic              angle_sine_ld,
  input  wire logic [31:0]       angle_cosine_in,
  input  wire logic              angle_cosine_ld,
  input  wire logic [31:0]       alpha_axis_current_in,
  input  wire logic              alpha_axis_current_ld,
  input  wire logic [31:0]       beta_axis_current_in,
  input  wire logic              beta_axis_current_ld,
  input  wire logic [31:0]       alpha_axis_voltage_in,
  input  wire logic              alpha_axis_voltage_ld
);

  // ----------------------------------------
  // constants and checks
  // ----------------------------------------
  localparam int N = `OBS_COUNT;
  localparam logic [10:0] OBS_IDX [N] = '{
    `IDX_SUPPLY_BUS_VOLTAGE, `IDX_PHASE_A_VOLTAGE,
    `IDX_PHASE_B_VOLTAGE,    `IDX_PHASE_C_VOLTAGE,
    `IDX_ANGLE_SINE,         `IDX_ANGLE_COSINE,
    `IDX_ALPHA_AXIS_CURRENT, `IDX_BETA_AXIS_CURRENT,
    `IDX_ALPHA_AXIS_VOLTAGE
  };

  generate
    if (ADDR_W < `MIN_ADDR_W || ADDR_W > 32) begin : g_bad_addr
      $error("address width cannot reach the register map");
    end
  endgenerate

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  foc_readback_pkg::bus_state_type state_q;
  foc_readback_pkg::bus_state_type state_d;

  logic [N-1:0]        strobe_w;
  logic [N-1:0]        isd_gate_w;
  logic [N-1:0]        load_en_w;
  logic [N-1:0][31:0]  in_w;
  logic [N-1:0][31:0]  val_w;
  logic [N-1:0]        hit_w;
  logic                ctrl_hit_w;
  logic                stat_hit_w;
  logic                req_w;
  logic                take_w;
  logic                done_w;
  logic                ctrl_wr_w;
  logic                freeze_w;
  logic [N-1:0]        rd_clr_w;
  logic [31:0]         status_w;
  logic [31:0]         rd_mux_w;
  logic [N-1:0]        fresh_q;
  logic [N-1:0]        fresh_d;
  logic [N-1:0]        seen_q;
  logic                freeze_q;
  logic                freeze_d;
  logic [31:0]         readdata_q;
  logic [31:0]         readdata_d;

  // ----------------------------------------
  // algorithm side gathering
  // ----------------------------------------
  assign strobe_w = {
    alpha_axis_voltage_ld, beta_axis_current_ld,
    alpha_axis_current_ld, angle_cosine_ld,
    angle_sine_ld,         phase_c_voltage_ld,
    phase_b_voltage_ld,    phase_a_voltage_ld,
    supply_bus_voltage_ld
  };

  assign in_w = {
    alpha_axis_voltage_in, beta_axis_current_in,
    alpha_axis_current_in, angle_cosine_in,
    angle_sine_in,         phase_c_voltage_in,
    phase_b_voltage_in,    phase_a_voltage_in,
    supply_bus_voltage_in
  };

  // phase words only move while speed detection runs, so the
  // last detection snapshot survives into the run phase
  assign isd_gate_w = {
    {5{1'b1}},
    {3{initial_speed_detection}},
    1'b1
  };

  // freeze lets software read a coherent set of words;
  // updates that arrive meanwhile are lost, not queued
  assign freeze_w  = freeze_q;
  assign load_en_w = strobe_w & isd_gate_w & {N{~freeze_w}};

  // ----------------------------------------
  // observation words
  // ----------------------------------------
  generate
    for (genvar g = 0; g < N; g++) begin : g_obs
      obs_word #(
        .WIDTH (`OBS_WIDTH)
      ) u_word (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .load     (load_en_w[g]),
        .value_in (in_w[g]),
        .value_q  (val_w[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  generate
    for (genvar h = 0; h < N; h++) begin : g_hit
      assign hit_w[h] = avs_address == ADDR_W'({OBS_IDX[h], 2'b00});
    end
  endgenerate

  assign ctrl_hit_w =
    avs_address == ADDR_W'({`IDX_READBACK_CONTROL, 2'b00});
  assign stat_hit_w =
    avs_address == ADDR_W'({`IDX_READBACK_STATUS, 2'b00});

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  // one wait cycle on every access keeps readdata a plain flop
  assign req_w   = avs_read | avs_write;
  assign take_w  = req_w && (state_q == foc_readback_pkg::BUS_IDLE);
  assign done_w  = state_q == foc_readback_pkg::BUS_ANSWER;
  assign state_d = take_w ? foc_readback_pkg::BUS_ANSWER
                          : foc_readback_pkg::BUS_IDLE;

  assign avs_waitrequest = take_w;
  assign avs_readdata    = readdata_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= foc_readback_pkg::BUS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  assign status_w = {
    14'h0000,
    freeze_w,
    initial_speed_detection,
    7'h00,
    fresh_q
  };

  always_comb begin
    rd_mux_w = 32'h00000000;
    for (int i = 0; i < N; i++) begin
      if (hit_w[i]) begin
        rd_mux_w = val_w[i];
      end
    end
    if (ctrl_hit_w) begin
      rd_mux_w = {31'h00000000, freeze_q};
    end
    if (stat_hit_w) begin
      rd_mux_w = status_w;
    end
  end

  assign readdata_d = (take_w && avs_read) ? rd_mux_w : readdata_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      readdata_q <= 32'h00000000;
    end else begin
      readdata_q <= readdata_d;
    end
  end

  // ----------------------------------------
  // freshness flags, cleared by a read
  // ----------------------------------------
  // cleared on the capture edge so a value loaded later is
  // still flagged; a load on that same edge wins
  assign rd_clr_w = {N{take_w && avs_read}} & hit_w;
  assign fresh_d  = load_en_w | (fresh_q & ~rd_clr_w);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fresh_q <= '0;
      seen_q  <= '0;
    end else begin
      fresh_q <= fresh_d;
      seen_q  <= seen_q | load_en_w;
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  // writes to observation words fall through here untouched
  assign ctrl_wr_w = done_w && avs_write && ctrl_hit_w
                     && avs_byteenable[0];
  assign freeze_d  = ctrl_wr_w ? avs_writedata[`CONTROL_FREEZE_BIT]
                               : freeze_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      freeze_q <= `CONTROL_RESET;
    end else begin
      freeze_q <= freeze_d;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  supply_voltage_load_a: assert property (
    supply_bus_voltage_ld && !freeze_q
    |=> val_w[0] == $past(supply_bus_voltage_in))
    else $error("bus voltage word missed its update");

  phase_a_isd_a: assert property (
    phase_a_voltage_ld && initial_speed_detection && !freeze_q
    |=> val_w[1] == $past(phase_a_voltage_in))
    else $error("phase A word missed detection update");

  phase_b_hold_a: assert property (
    !initial_speed_detection |=> $stable(val_w[2]))
    else $error("phase B word moved outside detection");

  phase_c_readback_a: assert property (
    take_w && avs_read && hit_w[3]
    |=> !avs_waitrequest && avs_readdata == $past(val_w[3]))
    else $error("phase C read returned wrong value");

  sine_load_a: assert property (
    angle_sine_ld && !freeze_q
    |=> val_w[4] == $past(angle_sine_in))
    else $error("sine word missed its update");

  cosine_read_a: assert property (
    take_w && avs_read && hit_w[5] && !angle_cosine_ld
    |=> ##1 avs_readdata == $past(val_w[5], 2))
    else $error("cosine read returned wrong value");

  alpha_current_load_a: assert property (
    alpha_axis_current_ld && !freeze_q
    |=> val_w[6] == $past(alpha_axis_current_in))
    else $error("alpha current word missed its update");

  beta_current_load_a: assert property (
    beta_axis_current_ld && !freeze_q
    |=> val_w[7] == $past(beta_axis_current_in))
    else $error("beta current word missed its update");

  generate
    for (genvar z = 0; z < N; z++) begin : g_zero
      reset_zero_a: assert property (
        !seen_q[z] |-> val_w[z] == `OBS_RESET)
        else $error("observation word nonzero before any load");
    end
  endgenerate

  alpha_voltage_load_a: assert property (
    alpha_axis_voltage_ld && !freeze_q
    |=> val_w[8] == $past(alpha_axis_voltage_in))
    else $error("alpha voltage word missed its update");

  write_ignored_a: assert property (
    avs_write && load_en_w == '0 |=> $stable(val_w))
    else $error("host write altered an observation word");

  fresh_set_wins_a: assert property (
    load_en_w[4] |=> fresh_q[4])
    else $error("fresh flag lost on simultaneous read");

  answer_one_wait_a: assert property (
    take_w |=> !avs_waitrequest ##1 !done_w)
    else $error("bus answer not after one wait cycle");

  readdata_hold_a: assert property (
    !(take_w && avs_read) |=> $stable(avs_readdata))
    else $error("read data moved without a read");

  frozen_sine_hold_a: assert property (
    freeze_q && angle_sine_ld |=> $stable(val_w[4]))
    else $error("sine word loaded while frozen");

  control_write_a: assert property (
    ctrl_wr_w |=> freeze_q == $past(avs_writedata[`CONTROL_FREEZE_BIT]))
    else $error("control write did not set freeze");

  unmapped_read_zero_a: assert property (
    take_w && avs_read && !(|hit_w) && !ctrl_hit_w && !stat_hit_w
    |=> avs_readdata == 32'h00000000)
    else $error("unmapped read returned nonzero data");

  fresh_read_clear_a: assert property (
    rd_clr_w[0] && !load_en_w[0] |=> !fresh_q[0])
    else $error("supply fresh flag kept after its read");

  phase_a_hold_a: assert property (
    !initial_speed_detection |=> $stable(val_w[1]))
    else $error("phase A word moved outside detection");

  phase_c_hold_a: assert property (
    !initial_speed_detection |=> $stable(val_w[3]))
    else $error("phase C word moved outside detection");

  read_waited_c: cover property (
    take_w && avs_read ##1 done_w);
  freeze_written_c: cover property (
    ctrl_wr_w && avs_writedata[`CONTROL_FREEZE_BIT]);
  fresh_race_c: cover property (
    |(rd_clr_w & load_en_w));
  isd_capture_c: cover property (
    initial_speed_detection && phase_c_voltage_ld);
  freeze_blocked_c: cover property (
    freeze_q && angle_sine_ld);

endmodule

//--- foc_algorithm_variable_readback_bench.sv
`timescale 1ns/1ps
`include "foc_readback_consts.svh"

module foc_algorithm_variable_readback_bench;
  // ----------------------------------------
  // stimulus and observation
  // ----------------------------------------
  logic        sys_clk;
  logic        rst;
  logic [12:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        initial_speed_detection;
  logic [31:0] val_in [9];
  logic        ld     [9];
  logic [31:0] rd;
  int          n_errors;
  int          tests_run;

  // slot order, supply word first
  localparam logic [10:0] obs_idx [9] = '{
    `IDX_SUPPLY_BUS_VOLTAGE, `IDX_PHASE_A_VOLTAGE, `IDX_PHASE_B_VOLTAGE,
    `IDX_PHASE_C_VOLTAGE, `IDX_ANGLE_SINE, `IDX_ANGLE_COSINE,
    `IDX_ALPHA_AXIS_CURRENT, `IDX_BETA_AXIS_CURRENT,
    `IDX_ALPHA_AXIS_VOLTAGE};
  localparam logic [12:0] ctrl_addr = {`IDX_READBACK_CONTROL, 2'b00};
  localparam logic [12:0] stat_addr = {`IDX_READBACK_STATUS, 2'b00};

  foc_algorithm_variable_readback dut (
    .sys_clk                 (sys_clk),
    .rst                     (rst),
    .avs_address             (avs_address),
    .avs_read                (avs_read),
    .avs_write               (avs_write),
    .avs_writedata           (avs_writedata),
    .avs_byteenable          (avs_byteenable),
    .avs_readdata            (avs_readdata),
    .avs_waitrequest         (avs_waitrequest),
    .initial_speed_detection (initial_speed_detection),
    .supply_bus_voltage_in   (val_in[0]),
    .supply_bus_voltage_ld   (ld[0]),
    .phase_a_voltage_in      (val_in[1]),
    .phase_a_voltage_ld      (ld[1]),
    .phase_b_voltage_in      (val_in[2]),
    .phase_b_voltage_ld      (ld[2]),
    .phase_c_voltage_in      (val_in[3]),
    .phase_c_voltage_ld      (ld[3]),
    .angle_sine_in           (val_in[4]),
    .angle_sine_ld           (ld[4]),
    .angle_cosine_in         (val_in[5]),
    .angle_cosine_ld         (ld[5]),
    .alpha_axis_current_in   (val_in[6]),
    .alpha_axis_current_ld   (ld[6]),
    .beta_axis_current_in    (val_in[7]),
    .beta_axis_current_ld    (ld[7]),
    .alpha_axis_voltage_in   (val_in[8]),
    .alpha_axis_voltage_ld   (ld[8])
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [12:0] addr_of(input int i);
    return {obs_idx[i], 2'b00};
  endfunction

  function automatic logic [31:0] pat(input int i);
    return 32'h9E370000 + 32'(i) * 32'h00011111;
  endfunction

  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // waitrequest and readdata are taken at the rising edge itself,
  // before that edge's own register updates land
  task automatic wait_answer();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      n_errors++;
      $display("unexpected waitrequest expected 0 seen %b", avs_waitrequest);
    end
  endtask

  task automatic bus_read(input logic [12:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read    <= 1'b1;
    wait_answer();
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic bus_write(input logic [12:0] a, input logic [31:0] d,
                           input logic [3:0] be);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= 1'b1;
    wait_answer();
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic load_word(input int i, input logic [31:0] v);
    val_in[i] <= v;
    ld[i]     <= 1'b1;
    @(posedge sys_clk);
    ld[i] <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic read_check(input string name, input logic [12:0] a,
                            input logic [31:0] exp);
    logic [31:0] d;
    bus_read(a, d);
    check(name, exp, d);
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // watchdog, far beyond the few hundred cycles used
  // ----------------------------------------
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    $display("unexpected watchdog expected done seen hang");
    complete_run();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    avs_address = 13'h0000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    initial_speed_detection = 1'b0;
    for (int i = 0; i < 9; i++) begin
      val_in[i] = 32'h00000000;
      ld[i] = 1'b0;
    end
    n_errors = 0;
    tests_run = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      read_check("reset word", addr_of(i), 32'h00000000);
    end
    read_check("control", ctrl_addr, 32'h00000000);
    // phase words only accept loads while detection runs
    initial_speed_detection <= 1'b1;
    for (int i = 0; i < 9; i++) load_word(i, pat(i));
    read_check("status fresh", stat_addr, 32'h000101FF);
    for (int i = 0; i < 9; i++) begin
      read_check("word", addr_of(i), pat(i));
    end
    read_check("status clear", stat_addr, 32'h00010000);
    for (int i = 0; i < 9; i++) begin
      bus_write(addr_of(i), 32'hFFFFFFFF, 4'hF);
      read_check("after write", addr_of(i), pat(i));
    end
    bus_write(13'h0100, 32'h5A5A5A5A, 4'hF);
    read_check("unmapped", 13'h0100, 32'h00000000);
    // capture outside detection must not reach the phase words
    initial_speed_detection <= 1'b0;
    for (int i = 1; i < 4; i++) begin
      load_word(i, 32'h0BAD0000);
      read_check("phase hold", addr_of(i), pat(i));
    end
    load_word(6, 32'h00C0FFEE);
    read_check("alpha current", addr_of(6), 32'h00C0FFEE);
    // freeze holds a coherent snapshot against algorithm loads
    bus_write(ctrl_addr, 32'h00000001, 4'h1);
    read_check("control set", ctrl_addr, 32'h00000001);
    load_word(4, 32'h11111111);
    read_check("frozen sine", addr_of(4), pat(4));
    read_check("status frozen", stat_addr, 32'h00020000);
    bus_write(ctrl_addr, 32'h00000000, 4'hE);
    read_check("control kept", ctrl_addr, 32'h00000001);
    bus_write(ctrl_addr, 32'h00000000, 4'h1);
    load_word(4, 32'h22222222);
    read_check("sine", addr_of(4), 32'h22222222);
    load_word(5, 32'hF8000000);
    read_check("cosine", addr_of(5), 32'hF8000000);
    do_reset();
    for (int i = 0; i < 9; i++) begin
      read_check("rereset", addr_of(i), 32'h00000000);
    end
    complete_run();
  end
endmodule
